// file: hw/sr_latch_pkg.sv
package sr_latch_pkg;
  // register byte offsets on the APB side
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] SRC_OFFSET = 12'h004;
  localparam logic [11:0] ALTPIN_OFFSET = 12'h008;
  localparam logic [11:0] STATUS_OFFSET = 12'h00C;
  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic ALTPIN_RESET = 1'b0;
  // control register fields
  localparam int CTRL_LEN_BIT = 7;
  localparam int CTRL_DIV_LSB = 4;
  localparam int CTRL_DIV_W = 3;
  localparam int CTRL_QEN_BIT = 3;
  localparam int CTRL_NQEN_BIT = 2;
  localparam int CTRL_SPULSE_BIT = 1;
  localparam int CTRL_RPULSE_BIT = 0;
  // source enable register fields (reset half sits four bits lower)
  localparam int SRC_PIN_BIT = 7;
  localparam int SRC_CLK_BIT = 6;
  localparam int SRC_C2_BIT = 5;
  localparam int SRC_C1_BIT = 4;
  localparam int SRC_RESET_SHIFT = 4;
  // alternate pin register field
  localparam int ALTPIN_NQSEL_BIT = 0;
  // divider: shortest period is 4 cycles, code 7 gives 512
  localparam int DIV_BASE_LOG2 = 2;
  localparam int DIV_CNT_W = 9;
  // firmware pulse width in cycles
  localparam int SOFT_PULSE_CYCLES = 1;
endpackage

// file: hw/pulse_divider.sv
`timescale 1ns/10ps
module pulse_divider
  import sr_latch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // period select and output pulse
  input wire logic [CTRL_DIV_W-1:0] sel,
  output logic pulse
);
  logic [DIV_CNT_W-1:0] cnt_q;
  logic [DIV_CNT_W-1:0] cnt_d;
  logic [DIV_CNT_W-1:0] mask;
  logic pulse_d;

  // period is 4 << sel, so the wrap mask is that minus one
  assign mask = DIV_CNT_W'((32'd1 << (DIV_BASE_LOG2 + 32'(sel))) - 32'd1);
  assign cnt_d = (cnt_q + 9'h001) & mask;
  assign pulse_d = ((cnt_q & mask) == mask);

  // free-running counter; a select change takes effect within one period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 9'h000;
      pulse <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pulse <= pulse_d;
    end
  end
endmodule // pulse_divider

// file: hw/cmp_sync.sv
`timescale 1ns/10ps
module cmp_sync
  import sr_latch_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // raw comparator, timer-1 clock enable, choice
  input wire logic raw,
  input wire logic tmr1_tick,
  input wire logic use_sync,
  output logic result
);
  logic held_q;

  // sample the comparator only on timer-1 clock ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= 1'b0;
    end else if (tmr1_tick) begin
      held_q <= raw;
    end
  end

  assign result = use_sync ? held_q : raw;
endmodule // cmp_sync

// file: hw/sr_latch.sv
`timescale 1ns/10ps
module sr_latch
  import sr_latch_pkg::*;
(
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // latch sources
  input wire logic cmp1_result,
  input wire logic cmp2_result,
  input wire logic cmp1_sync_sel,
  input wire logic cmp2_sync_sel,
  input wire logic tmr1_tick,
  input wire logic latch_input_pin,
  // output pins with enables
  output logic true_output_pin,
  output logic true_output_oe,
  output logic complement_output_pin,
  output logic complement_output_oe,
  output logic complement_alt_pin,
  output logic complement_alt_oe
);
  logic [7:0] ctrl_q;
  logic [7:0] src_q;
  logic altpin_q;
  logic spulse_q;
  logic rpulse_q;
  logic state_q;
  logic state_d;
  logic div_pulse;
  logic comparator1_result_synced;
  logic comparator2_result_synced;
  logic set_any;
  logic reset_any;
  logic [3:0] src_vec;

  // bus decode
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire sel_ctrl = (paddr == CTRL_OFFSET);
  wire sel_src = (paddr == SRC_OFFSET);
  wire sel_alt = (paddr == ALTPIN_OFFSET);
  wire sel_stat = (paddr == STATUS_OFFSET);
  wire mapped = sel_ctrl | sel_src | sel_alt | sel_stat;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // field views
  wire latch_enable = ctrl_q[CTRL_LEN_BIT];
  wire [CTRL_DIV_W-1:0] pulse_divider_select =
    ctrl_q[CTRL_DIV_LSB +: CTRL_DIV_W];
  wire true_output_enable = ctrl_q[CTRL_QEN_BIT];
  wire complement_output_enable = ctrl_q[CTRL_NQEN_BIT];
  wire complement_pin_relocate = altpin_q;

  // control registers; pulse bits are not stored, they read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
      src_q <= SRC_RESET;
      altpin_q <= ALTPIN_RESET;
    end else if (wr) begin
      if (sel_ctrl) ctrl_q <= pwdata[7:0] & 8'hFC;
      if (sel_src) src_q <= pwdata[7:0];
      if (sel_alt) altpin_q <= pwdata[ALTPIN_NQSEL_BIT];
    end
  end

  // firmware pulses: one cycle high after a write of one, then gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spulse_q <= 1'b0;
      rpulse_q <= 1'b0;
    end else begin
      spulse_q <= wr & sel_ctrl & pwdata[CTRL_SPULSE_BIT];
      rpulse_q <= wr & sel_ctrl & pwdata[CTRL_RPULSE_BIT];
    end
  end

  // read mux; status shows latch state and live combined inputs
  always_comb begin
    prdata = 32'h00000000;
    if (access && !pwrite) begin
      if (sel_ctrl) prdata = {24'h000000, ctrl_q};
      if (sel_src) prdata = {24'h000000, src_q};
      if (sel_alt) prdata = {31'h00000000, altpin_q};
      if (sel_stat) prdata = {29'h00000000, reset_any, set_any, state_q};
    end
  end

  pulse_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .sel(pulse_divider_select),
    .pulse(div_pulse)
  );

  cmp_sync u_c1 (
    .pclk(pclk),
    .presetn(presetn),
    .raw(cmp1_result),
    .tmr1_tick(tmr1_tick),
    .use_sync(cmp1_sync_sel),
    .result(comparator1_result_synced)
  );

  cmp_sync u_c2 (
    .pclk(pclk),
    .presetn(presetn),
    .raw(cmp2_result),
    .tmr1_tick(tmr1_tick),
    .use_sync(cmp2_sync_sel),
    .result(comparator2_result_synced)
  );

  // source vector in the bit order of each enable half
  assign src_vec = {latch_input_pin, div_pulse,
                    comparator2_result_synced, comparator1_result_synced};
  assign set_any = spulse_q
                 | (|(src_vec & src_q[7:4]));
  assign reset_any = rpulse_q
                   | (|(src_vec & src_q[3:0]));

  // reset dominates; otherwise set; otherwise hold
  assign state_d = reset_any ? 1'b0 : (set_any ? 1'b1 : state_q);

  // state flop runs regardless of enable; a clocked hold stands in for
  // the clockless latch, trading a cycle of lag for a clean design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= 1'b0; // latch leaves reset in the reset state, Q low
    end else begin
      state_q <= state_d;
    end
  end

  // output drive; direction control is firmware's job on the port
  wire q_on = latch_enable & true_output_enable;
  wire nq_on = latch_enable & complement_output_enable;
  assign true_output_pin = state_q;
  assign true_output_oe = q_on;
  assign complement_output_pin = ~state_q;
  assign complement_output_oe = nq_on & ~complement_pin_relocate;
  assign complement_alt_pin = ~state_q;
  assign complement_alt_oe = nq_on & complement_pin_relocate;

  // checks
  a_reset_dominant: assert property (@(posedge pclk) disable iff (!presetn)
    reset_any |=> !state_q) else $error("reset did not win");
  a_set_takes: assert property (@(posedge pclk) disable iff (!presetn)
    set_any && !reset_any |=> state_q) else $error("set lost");
  a_hold_state: assert property (@(posedge pclk) disable iff (!presetn)
    !set_any && !reset_any |=> $stable(state_q))
    else $error("state moved without input");
  a_pulse_one: assert property (@(posedge pclk) disable iff (!presetn)
    spulse_q |=> !spulse_q || $past(wr && sel_ctrl))
    else $error("set pulse too long");
  a_pulse_read: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && sel_ctrl |-> prdata[1:0] == 2'b00)
    else $error("pulse bits read nonzero");
  a_pulse_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr && sel_ctrl && pwdata[0] |=> rpulse_q ##1
    (!rpulse_q || $past(wr && sel_ctrl)))
    else $error("reset pulse wrong");
  a_oe_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_enable |-> !true_output_oe && !complement_output_oe
    && !complement_alt_oe) else $error("output without enable");
  a_nq_relocate: assert property (@(posedge pclk) disable iff (!presetn)
    complement_output_oe |-> !complement_alt_oe && !altpin_q)
    else $error("complement on both pins");
endmodule // sr_latch

// file: testbench/src_far_side.sv
`timescale 1ns/10ps
// comparators, latch input pin and timer-1 tick seen by the latch
module src_far_side (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // requested levels {pin, c2, c1}
  input wire logic [2:0] lvl,
  // source outputs
  output logic cmp1_result,
  output logic cmp2_result,
  output logic latch_input_pin,
  output logic tmr1_tick
);
  logic [2:0] tick_q;
  // levels move just after an edge, as a real source would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {latch_input_pin, cmp2_result, cmp1_result} <= 3'h0;
      tick_q <= 3'h0;
    end else begin
      {latch_input_pin, cmp2_result, cmp1_result} <= lvl;
      tick_q <= tick_q + 3'h1;
    end
  end
  // tick every eighth cycle, slower than the bus clock
  assign tmr1_tick = (tick_q == 3'h7);
endmodule // src_far_side

// file: testbench/test_set_reset_latch.sv
`timescale 1ns/10ps
module test_set_reset_latch;
  import sr_latch_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, last_err, c1, c2, pin, tick, q, sy1 = 0, sy2 = 0;
  logic tq, toe, nq, noe, aq, aoe;
  logic [2:0] lvl = 3'h0, e;
  logic [7:0] en, ep = 8'h00;
  int err_count = 0, n_tests = 0, seed = 82, n;
  sr_latch i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp1_result(c1), .cmp2_result(c2), .cmp1_sync_sel(sy1),
    .cmp2_sync_sel(sy2), .tmr1_tick(tick), .latch_input_pin(pin),
    .true_output_pin(tq), .true_output_oe(toe),
    .complement_output_pin(nq), .complement_output_oe(noe),
    .complement_alt_pin(aq), .complement_alt_oe(aoe));
  src_far_side i_far (.pclk(pclk), .presetn(presetn), .lvl(lvl),
    .cmp1_result(c1), .cmp2_result(c2), .latch_input_pin(pin),
    .tmr1_tick(tick));
  always #5 pclk = ~pclk;
  // one apb transfer; an idle edge after it keeps drivers single
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic ck(string nm, logic [31:0] x, logic [31:0] s);
    n_tests++;
    if (s !== x) begin
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
      err_count++;
    end
  endtask
  // edges until the next fall of the true output
  task automatic fall();
    n = 0;
    do begin @(posedge pclk); n++; end while (tq !== 1'b1);
    do begin @(posedge pclk); n++; end while (tq !== 1'b0);
  endtask
  // expected {reset_any, set_any, state}; reset dominates
  function automatic logic [2:0] exp_st(logic [7:0] m, logic [2:0] l,
      logic s0);
    logic s, r;
    s = |(m[7:4] & {l[2], 1'b0, l[1], l[0]});
    r = |(m[3:0] & {l[2], 1'b0, l[1], l[0]});
    return {r, s, r ? 1'b0 : (s | s0)};
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, CTRL_OFFSET, 0); ck("ctrl rst", 32'h0, rd);
    apb(0, SRC_OFFSET, 0); ck("src rst", 32'h0, rd);
    apb(0, ALTPIN_OFFSET, 0); ck("alt rst", 32'h0, rd);
    apb(0, 12'h010, 0); ck("unmapped err", 1, last_err);
    $display("test reset done");
    // latch is put in a known state before outputs are enabled
    apb(1, CTRL_OFFSET, 32'h83);
    apb(0, STATUS_OFFSET, 0); ck("both pulses", 0, rd[0]);
    apb(1, CTRL_OFFSET, 32'h8A);
    apb(0, STATUS_OFFSET, 0); ck("set pulse", 1, rd[0]);
    apb(0, CTRL_OFFSET, 0); ck("ctrl read", 32'h88, rd);
    apb(1, CTRL_OFFSET, 32'h88);
    apb(0, STATUS_OFFSET, 0); ck("zero write", 1, rd[0]);
    ck("true pin", 1, tq);
    $display("test firmware done");
    q = 1;
    // random source enables and levels, clock sources left off
    repeat (60) begin
      en = $random(seed) & 8'hBB;
      lvl <= $random(seed);
      apb(1, SRC_OFFSET, {24'h0, en});
      apb(0, SRC_OFFSET, 0); ck("src read", {24'h0, en}, rd);
      // new levels meet the old enables for one cycle first
      e = exp_st(ep, lvl, q);
      q = e[0];
      e = exp_st(en, lvl, q);
      q = e[0];
      ep = en;
      apb(0, STATUS_OFFSET, 0); ck("status", {29'h0, e}, rd);
    end
    $display("test sources done");
    // synced comparator ignores a new level until the next timer tick
    sy1 <= 1;
    lvl <= 3'h0;
    apb(1, SRC_OFFSET, 32'h10);
    repeat (16) @(posedge pclk);
    do @(posedge pclk); while (tick !== 1'b1);
    lvl <= 3'h1;
    apb(0, STATUS_OFFSET, 0); ck("sync held", 0, rd[1]);
    repeat (16) @(posedge pclk);
    apb(0, STATUS_OFFSET, 0); ck("sync set", 1, rd[1]);
    sy1 <= 0;
    $display("test sync done");
    // pin sets, clock resets: output falls once per divider period
    lvl <= 3'h4;
    apb(1, SRC_OFFSET, 32'h84);
    for (int s = 0; s < 8; s++) begin
      apb(1, CTRL_OFFSET, 32'h88 | (s << 4));
      fall();
      fall();
      ck("divider period", 4 << s, n);
    end
    $display("test divider done");
    lvl <= 3'h0;
    apb(1, SRC_OFFSET, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1, ALTPIN_OFFSET, i >> 3);
      apb(1, CTRL_OFFSET, {i[2], 3'h0, i[1], i[0], 2'h0});
      ck("true oe", i[2] & i[1], toe);
      ck("comp oe", i[2] & i[0] & !i[3], noe);
      ck("alt oe", i[2] & i[0] & i[3], aoe);
      ck("comp pins", {~tq, ~tq}, {nq, aq});
    end
    $display("test outputs done");
    // reset in mid-run clears the registers again
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, CTRL_OFFSET, 0); ck("ctrl rerst", 32'h0, rd);
    ck("true oe rerst", 0, toe);
    $display("test mid reset done");
    final_report();
  end
endmodule // test_set_reset_latch
